// ---- design/mccu_pkg.sv ----
// Purpose: Shared constants for the measurement condition command unit.
// Assumes: Operand words are 16 bits, sent one per clock from the host.
// Notes:   Both ends and the carrier interface use these names.
package mccu_pkg;

    localparam int unsigned WORD_W      = 16;
    localparam int unsigned FRAME_WORDS = 25;
    localparam int unsigned IDX_W       = 5;
    localparam int unsigned MSW_WORDS   = 4;
    localparam int unsigned LIM_W       = 29;

    typedef logic [1:0] mccu_op_t;
    localparam mccu_op_t OP_INIT    = 2'h0;
    localparam mccu_op_t OP_SET     = 2'h1;
    localparam mccu_op_t OP_RELEASE = 2'h2;

    localparam logic [WORD_W-1:0] SET_COUNT = 16'h0025;

    localparam logic [IDX_W-1:0] OFS_SEG   = 5'h01;
    localparam logic [IDX_W-1:0] OFS_INTV  = 5'h02;
    localparam logic [IDX_W-1:0] OFS_LOWER = 5'h03;
    localparam logic [IDX_W-1:0] OFS_UPPER = 5'h06;
    localparam logic [IDX_W-1:0] OFS_REF   = 5'h09;
    localparam logic [IDX_W-1:0] OFS_SCALE = 5'h0c;
    localparam logic [IDX_W-1:0] OFS_OCOND = 5'h10;
    localparam logic [IDX_W-1:0] OFS_OTIM  = 5'h11;
    localparam logic [IDX_W-1:0] OFS_LATCH = 5'h12;
    localparam logic [IDX_W-1:0] OFS_FLAG  = 5'h13;
    localparam int unsigned      NUM_FLAGS = 6;

    localparam logic [7:0] SIGN_POS = 8'h20;
    localparam logic [7:0] SIGN_NEG = 8'h2d;

    localparam logic [3:0] SEG_MIN   = 4'h1;
    localparam logic [3:0] SEG_MAX   = 4'h5;
    localparam logic [3:0] INTV_MIN  = 4'h1;
    localparam logic [3:0] INTV_MAX  = 4'h7;
    localparam logic [3:0] SCALE_MAX = 4'h3;
    localparam logic [3:0] OCOND_MAX = 4'h6;
    localparam logic [3:0] FLAG_MAX  = 4'h1;
    localparam logic [3:0] RELEASE_SEG  = 4'h1;
    localparam logic [3:0] RELEASE_INTV = 4'h1;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_RECV = 3'b010,
        DEV_EXEC = 3'b100
    } mccu_dev_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b001,
        HOST_SEND = 3'b010,
        HOST_WAIT = 3'b100
    } mccu_host_state_e;

endpackage

// ---- design/mccu_if.sv ----
`timescale 1ns/1ps
// Purpose: Operand word channel between host controller and command unit.
// Assumes: Both ends run on the same ref_clk.
// Notes:   A word moves on a clock edge where vld and rdy are both high.
interface mccu_if;
    mccu_pkg::mccu_op_t            op;    // Operation of this frame
    logic                          vld;   // Host word valid
    logic [mccu_pkg::WORD_W-1:0]   data;  // Operand word
    logic                          last;  // Final word of the frame
    logic                          rdy;   // Device can take a word
    logic                          done;  // Operation finished, pulse
    logic                          err;   // Operation rejected, pulse

    modport host (output op, output vld, output data, output last,
                  input rdy, input done, input err);
    modport dev  (input op, input vld, input data, input last,
                  output rdy, output done, output err);
endinterface

// ---- design/mccu_dev.sv ----
`timescale 1ns/1ps
// Purpose: Command unit end: collects operand words and applies them.
// Assumes: One clock; config switch input is asynchronous to it.
// Notes:   Settings are held and driven to the micrometer command side.
module mccu_dev (
    input  wire logic                     ref_clk,      // System clock
    input  wire logic                     arst_n,       // Async reset
    mccu_if.dev                           lnk,          // Host channel
    input  wire logic                     sw2_bit8_en,  // Switch bank bit 8
    output logic                          mic_reset,    // Reset pulse
    output logic                          stat_clear,   // Stats erase pulse
    output logic                          unit_mm,      // Millimetre units
    output logic                          stat_en,      // Statistics on
    output logic [mccu_pkg::MSW_WORDS*mccu_pkg::WORD_W-1:0]
                                          memsw,        // Memory switches
    output logic [3:0]                    segment_select, // Segment
    output logic [3:0]                    interval_sel, // Interval
    output logic                          limit_en,     // Limits active
    output logic [mccu_pkg::LIM_W-1:0]    lower_limit_value, // Lower
    output logic [mccu_pkg::LIM_W-1:0]    upper_limit_value, // Upper
    output logic                          ref_en,       // Reference active
    output logic [mccu_pkg::LIM_W-1:0]    ref_value,    // Reference
    output logic [3:0]                    scale_sel,    // Analog scale
    output logic                          ocond_en,     // Output pair active
    output logic [3:0]                    output_condition, // Condition
    output logic [11:0]                   output_timer_value, // Timer
    output logic [7:0]                    latch_timer_seconds // Latch
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mccu_pkg::mccu_dev_state_e                st;
        logic                                     rdy;
        logic                                     done;
        logic                                     err;
        logic [mccu_pkg::IDX_W-1:0]               idx;
        mccu_pkg::mccu_op_t                       op;
        logic [mccu_pkg::FRAME_WORDS-1:0][mccu_pkg::WORD_W-1:0] frame;
        logic                                     sw8_m;
        logic                                     sw8_s;
        logic                                     mic_reset;
        logic                                     stat_clear;
        logic                                     unit_mm;
        logic                                     stat_en;
        logic [mccu_pkg::MSW_WORDS-1:0][mccu_pkg::WORD_W-1:0] memsw;
        logic [3:0]                               seg;
        logic [3:0]                               intv;
        logic                                     lim_en;
        logic [mccu_pkg::LIM_W-1:0]               lower;
        logic [mccu_pkg::LIM_W-1:0]               upper;
        logic                                     ref_en;
        logic [mccu_pkg::LIM_W-1:0]               refv;
        logic [3:0]                               scale;
        logic                                     ocond_en;
        logic [3:0]                               ocond;
        logic [11:0]                              otim;
        logic [7:0]                               latch;
    } mccu_dev_s;

    mccu_dev_s s_q;
    mccu_dev_s s_d;

    // ------------------------------------------------------------
    // Field helpers
    // ------------------------------------------------------------
    function automatic logic bcd_ok(input logic [15:0] w,
                                    input int unsigned n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (i < n && w[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic sign_ok(input logic [15:0] w);
        return (w[15:8] == mccu_pkg::SIGN_POS) ||
               (w[15:8] == mccu_pkg::SIGN_NEG);
    endfunction

    // Packs fraction, integer and sign into one held limit value.
    function automatic logic [mccu_pkg::LIM_W-1:0] pack_lim(
        input logic [15:0] fr, input logic [15:0] in, input logic [15:0] sg);
        return {sg[15:8] == mccu_pkg::SIGN_NEG, in[11:0], fr};
    endfunction

    // ------------------------------------------------------------
    // Frame checks
    // ------------------------------------------------------------
    logic [mccu_pkg::NUM_FLAGS-1:0] flag;
    logic                           flags_ok;
    logic                           set_ok;
    logic                           full_frame;

    always_comb begin
        logic [15:0] w;
        logic [mccu_pkg::IDX_W-1:0] b;
        w = '0;
        b = '0;
        flags_ok = 1'b1;
        for (int i = 0; i < mccu_pkg::NUM_FLAGS; i++) begin
            w = s_q.frame[mccu_pkg::OFS_FLAG + i[mccu_pkg::IDX_W-1:0]];
            flag[i] = w[0];
            if (!bcd_ok(w, 1) || w[3:0] > mccu_pkg::FLAG_MAX) begin
                flags_ok = 1'b0;
            end
        end
        full_frame = s_q.idx ==
                     mccu_pkg::IDX_W'(mccu_pkg::FRAME_WORDS);
        set_ok = flags_ok && full_frame &&
                 s_q.frame[0] == mccu_pkg::SET_COUNT;
        w = s_q.frame[mccu_pkg::OFS_SEG];
        if (!bcd_ok(w, 1) || w[3:0] < mccu_pkg::SEG_MIN ||
            w[3:0] > mccu_pkg::SEG_MAX) begin
            set_ok = 1'b0;
        end
        w = s_q.frame[mccu_pkg::OFS_INTV];
        if (!bcd_ok(w, 1) || w[3:0] < mccu_pkg::INTV_MIN ||
            w[3:0] > mccu_pkg::INTV_MAX) begin
            set_ok = 1'b0;
        end
        for (int k = 0; k < 3; k++) begin
            b = mccu_pkg::OFS_LOWER + 5'(3 * k);
            if (!bcd_ok(s_q.frame[b], 4) || !bcd_ok(s_q.frame[b + 5'h01], 3)
                || !sign_ok(s_q.frame[b + 5'h02])) begin
                set_ok = 1'b0;
            end
        end
        w = s_q.frame[mccu_pkg::OFS_SCALE];
        if (!bcd_ok(w, 1) || w[3:0] > mccu_pkg::SCALE_MAX) begin
            set_ok = 1'b0;
        end
        w = s_q.frame[mccu_pkg::OFS_OCOND];
        if (!bcd_ok(w, 1) || w[3:0] > mccu_pkg::OCOND_MAX) begin
            set_ok = 1'b0;
        end
        if (!bcd_ok(s_q.frame[mccu_pkg::OFS_OTIM], 3) ||
            !bcd_ok(s_q.frame[mccu_pkg::OFS_LATCH], 2)) begin
            set_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        s_d.mic_reset = 1'b0;
        s_d.stat_clear = 1'b0;
        s_d.sw8_m = sw2_bit8_en;
        s_d.sw8_s = s_q.sw8_m;
        unique case (s_q.st)
            mccu_pkg::DEV_IDLE: begin
                s_d.rdy = 1'b1;
                s_d.idx = '0;
                if (lnk.vld && s_q.rdy) begin
                    s_d.op = lnk.op;
                    s_d.frame[0] = lnk.data;
                    s_d.idx = 5'h01;
                    s_d.st = lnk.last ? mccu_pkg::DEV_EXEC
                                      : mccu_pkg::DEV_RECV;
                    s_d.rdy = !lnk.last;
                end
            end
            mccu_pkg::DEV_RECV: begin
                if (lnk.vld) begin
                    // Surplus words are dropped but counted, so an
                    // overlong set frame is caught by the length check.
                    if (s_q.idx < mccu_pkg::IDX_W'(mccu_pkg::FRAME_WORDS)) begin
                        s_d.frame[s_q.idx] = lnk.data;
                    end
                    if (s_q.idx != '1) begin
                        s_d.idx = s_q.idx + 5'h01;
                    end
                    if (lnk.last) begin
                        s_d.st = mccu_pkg::DEV_EXEC;
                        s_d.rdy = 1'b0;
                    end
                end
            end
            mccu_pkg::DEV_EXEC: begin
                s_d.st = mccu_pkg::DEV_IDLE;
                s_d.rdy = 1'b1;
                s_d.done = 1'b1;
                if (s_q.op == mccu_pkg::OP_INIT) begin
                    if (s_q.idx < mccu_pkg::IDX_W'(mccu_pkg::MSW_WORDS + 1)) begin
                        s_d.done = 1'b0;
                        s_d.err = 1'b1;
                    end else begin
                        s_d.mic_reset = 1'b1;
                        s_d.stat_clear = 1'b1;
                        s_d.unit_mm = 1'b1;
                        s_d.stat_en = 1'b0;
                        for (int i = 0; i < mccu_pkg::MSW_WORDS; i++) begin
                            s_d.memsw[i] = s_q.frame[i + 1];
                        end
                    end
                end else if (s_q.op == mccu_pkg::OP_SET) begin
                    if (!set_ok) begin
                        s_d.done = 1'b0;
                        s_d.err = 1'b1;
                    end else begin
                        if (flag[0]) begin
                            s_d.seg = s_q.frame[mccu_pkg::OFS_SEG][3:0];
                        end
                        if (flag[1]) begin
                            s_d.intv = s_q.frame[mccu_pkg::OFS_INTV][3:0];
                        end
                        if (flag[2]) begin
                            s_d.lim_en = 1'b1;
                            s_d.lower = pack_lim(
                                s_q.frame[mccu_pkg::OFS_LOWER],
                                s_q.frame[mccu_pkg::OFS_LOWER + 5'h01],
                                s_q.frame[mccu_pkg::OFS_LOWER + 5'h02]);
                            s_d.upper = pack_lim(
                                s_q.frame[mccu_pkg::OFS_UPPER],
                                s_q.frame[mccu_pkg::OFS_UPPER + 5'h01],
                                s_q.frame[mccu_pkg::OFS_UPPER + 5'h02]);
                        end
                        if (flag[3]) begin
                            s_d.ref_en = 1'b1;
                            s_d.refv = pack_lim(
                                s_q.frame[mccu_pkg::OFS_REF],
                                s_q.frame[mccu_pkg::OFS_REF + 5'h01],
                                s_q.frame[mccu_pkg::OFS_REF + 5'h02]);
                            s_d.scale = s_q.frame[mccu_pkg::OFS_SCALE][3:0];
                        end
                        if (flag[4]) begin
                            s_d.ocond_en = 1'b1;
                            s_d.ocond = s_q.frame[mccu_pkg::OFS_OCOND][3:0];
                            s_d.otim = s_q.frame[mccu_pkg::OFS_OTIM][11:0];
                        end
                        if (flag[5]) begin
                            s_d.latch = s_q.frame[mccu_pkg::OFS_LATCH][7:0];
                        end
                    end
                end else begin
                    if (!flags_ok || !s_q.sw8_s) begin
                        s_d.done = 1'b0;
                        s_d.err = 1'b1;
                    end else begin
                        s_d.seg = mccu_pkg::RELEASE_SEG;
                        s_d.intv = mccu_pkg::RELEASE_INTV;
                        if (flag[2]) begin
                            s_d.lim_en = 1'b0;
                            s_d.lower = '0;
                            s_d.upper = '0;
                        end
                        if (flag[3]) begin
                            s_d.ref_en = 1'b0;
                            s_d.refv = '0;
                        end
                        if (flag[4]) begin
                            s_d.ocond_en = 1'b0;
                            s_d.ocond = '0;
                        end
                        if (flag[5]) begin
                            s_d.latch = '0;
                        end
                    end
                end
            end
            default: begin
                s_d.st = mccu_pkg::DEV_IDLE;
                s_d.rdy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.st <= mccu_pkg::DEV_IDLE;
            s_q.seg <= mccu_pkg::RELEASE_SEG;
            s_q.intv <= mccu_pkg::RELEASE_INTV;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign lnk.rdy = s_q.rdy;
    assign lnk.done = s_q.done;
    assign lnk.err = s_q.err;
    assign mic_reset = s_q.mic_reset;
    assign stat_clear = s_q.stat_clear;
    assign unit_mm = s_q.unit_mm;
    assign stat_en = s_q.stat_en;
    assign memsw = s_q.memsw;
    assign segment_select = s_q.seg;
    assign interval_sel = s_q.intv;
    assign limit_en = s_q.lim_en;
    assign lower_limit_value = s_q.lower;
    assign upper_limit_value = s_q.upper;
    assign ref_en = s_q.ref_en;
    assign ref_value = s_q.refv;
    assign scale_sel = s_q.scale;
    assign ocond_en = s_q.ocond_en;
    assign output_condition = s_q.ocond;
    assign output_timer_value = s_q.otim;
    assign latch_timer_seconds = s_q.latch;

endmodule

// ---- design/mccu_host.sv ----
`timescale 1ns/1ps
// Purpose: Host controller end: streams one operand frame per request.
// Assumes: The user holds frame_in only during the start cycle.
// Notes:   Set and release frames always carry the fixed word count.
module mccu_host (
    input  wire logic                     ref_clk,   // System clock
    input  wire logic                     arst_n,    // Async reset
    mccu_if.host                          lnk,       // Device channel
    input  wire logic                     start,     // Request pulse
    input  wire mccu_pkg::mccu_op_t       op,        // Requested operation
    input  wire logic [mccu_pkg::FRAME_WORDS-1:0][mccu_pkg::WORD_W-1:0]
                                          frame_in,  // Operand words
    input  wire logic [mccu_pkg::IDX_W-1:0] frame_len, // Init frame length
    output logic                          busy,      // Request in flight
    output logic                          done,      // Accepted, pulse
    output logic                          err        // Rejected, pulse
);

    typedef struct packed {
        mccu_pkg::mccu_host_state_e               st;
        logic                                     busy;
        logic                                     vld;
        logic                                     last;
        logic [mccu_pkg::WORD_W-1:0]              data;
        mccu_pkg::mccu_op_t                       op;
        logic [mccu_pkg::IDX_W-1:0]               idx;
        logic [mccu_pkg::IDX_W-1:0]               len;
        logic [mccu_pkg::FRAME_WORDS-1:0][mccu_pkg::WORD_W-1:0] frame;
        logic                                     done;
        logic                                     err;
    } mccu_host_s;

    mccu_host_s h_q;
    mccu_host_s h_d;

    always_comb begin
        logic [mccu_pkg::IDX_W-1:0] len;
        len = (op == mccu_pkg::OP_INIT) ? frame_len
                                        : mccu_pkg::IDX_W'(mccu_pkg::FRAME_WORDS);
        // A zero length would not raise last until the 5-bit index wraps, so it is sent as one word.
        if (len == '0) begin
            len = 5'h01;
        end
        h_d = h_q;
        h_d.done = 1'b0;
        h_d.err = 1'b0;
        unique case (h_q.st)
            mccu_pkg::HOST_IDLE: begin
                if (start) begin
                    h_d.frame = frame_in;
                    if (op != mccu_pkg::OP_INIT) begin
                        h_d.frame[0] = mccu_pkg::SET_COUNT;
                    end
                    h_d.op = op;
                    h_d.len = len;
                    h_d.idx = '0;
                    h_d.data = h_d.frame[0];
                    h_d.vld = 1'b1;
                    h_d.last = len == 5'h01;
                    h_d.busy = 1'b1;
                    h_d.st = mccu_pkg::HOST_SEND;
                end
            end
            mccu_pkg::HOST_SEND: begin
                if (lnk.rdy) begin
                    if (h_q.last) begin
                        h_d.vld = 1'b0;
                        h_d.last = 1'b0;
                        h_d.st = mccu_pkg::HOST_WAIT;
                    end else begin
                        h_d.idx = h_q.idx + 5'h01;
                        h_d.data = h_q.frame[h_q.idx + 5'h01];
                        h_d.last = h_q.idx + 5'h02 == h_q.len;
                    end
                end
            end
            mccu_pkg::HOST_WAIT: begin
                if (lnk.done || lnk.err) begin
                    h_d.done = lnk.done;
                    h_d.err = lnk.err;
                    h_d.busy = 1'b0;
                    h_d.st = mccu_pkg::HOST_IDLE;
                end
            end
            default: begin
                h_d.st = mccu_pkg::HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            h_q <= '0;
            h_q.st <= mccu_pkg::HOST_IDLE;
        end else begin
            h_q <= h_d;
        end
    end

    assign lnk.op = h_q.op;
    assign lnk.vld = h_q.vld;
    assign lnk.data = h_q.data;
    assign lnk.last = h_q.last;
    assign busy = h_q.busy;
    assign done = h_q.done;
    assign err = h_q.err;

endmodule

// ---- bench/mccu_sva.sv ----
// Purpose: Link timing checks between host end and command unit.
// Assumes: One clock; arst_n is active low.
// Notes:   Settings are judged by the bench model.
`timescale 1ns/1ps
module mccu_sva (
    input wire logic               ref_clk, // Clock
    input wire logic               arst_n,  // Reset
    input wire mccu_pkg::mccu_op_t op,      // Operation
    input wire logic               vld,     // Valid
    input wire logic [15:0]        data,    // Word
    input wire logic               last,    // Final word
    input wire logic               rdy,     // Ready
    input wire logic               done,    // Done pulse
    input wire logic               err      // Error pulse
);
    logic [4:0] cnt_q;
    wire        take = vld && rdy;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Word position in the frame, so count and length can be tied to it.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            cnt_q <= 5'h00;
        else if (take)
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
    end
    a_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    a_err_pulse: assert property (err |=> !err)
        else $error("err too long");
    a_answer_excl: assert property (!(done && err))
        else $error("done with err");
    a_answer_time: assert property (take && last |=>
        !rdy && !done && !err ##1 (done || err) && rdy) else $error("late");
    a_quiet_frame: assert property (take && !last |=> !done && !err)
        else $error("early answer");
    a_word_hold: assert property (vld && !rdy |=>
        vld && $stable({data, last, op})) else $error("word not held");
    a_count_word: assert property (take && cnt_q == 5'h00 &&
        op != mccu_pkg::OP_INIT |-> data == mccu_pkg::SET_COUNT)
        else $error("bad count word");
    a_frame_len: assert property (take && last &&
        op != mccu_pkg::OP_INIT |-> cnt_q == 5'h18) else $error("length");
    c_set_ok: cover property (take && last && op == mccu_pkg::OP_SET ##2 done);
    c_set_bad: cover property (take && last && op == mccu_pkg::OP_SET ##2 err);
    c_rel: cover property (take && last && op == mccu_pkg::OP_RELEASE ##2 done);
endmodule

// ---- bench/measure_condition_command_unit_bench.sv ----
// Purpose: Runs init, set and release frames through both ends.
// Assumes: Host and unit share ref_clk and one link.
// Notes:   A bench model tracks the expected settings.
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module measure_condition_command_unit_bench;
    logic ref_clk = 0, arst_n = 0, start = 0, sw2 = 0;
    logic h_busy, h_done, h_err, m_rst, s_clr, mm, s_en, le, re, oe;
    logic [63:0] msw;
    logic [3:0] sg, iv, sc, oc, e_sg = 1, e_iv = 1, e_sc = 0, e_oc = 0;
    logic [28:0] lo, up, rf, e_lo = 0, e_up = 0, e_rf = 0;
    logic [11:0] tm, e_tm = 0;
    logic [7:0] lt, e_lt = 0;
    logic [4:0] flen = 5'h05;
    logic e_le = 0, e_re = 0, e_oe = 0;
    logic [24:0][15:0] f = '0;
    mccu_pkg::mccu_op_t op = mccu_pkg::OP_INIT;
    int seed = 88034, miscompares = 0, check_count = 0, cyc = 0;
    int bi[6] = '{1, 2, 5, 12, 17, 20};
    logic [15:0] bv[6] = '{16'h0006, 16'h0008, 16'h2b00, 16'h0004,
                           16'h00a0, 16'h0002};
    mccu_if lnk ();
    mccu_host u_mccu_host (.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk.host),
        .start(start), .op(op), .frame_in(f), .frame_len(flen),
        .busy(h_busy), .done(h_done), .err(h_err));
    mccu_dev u_mccu_dev (.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk.dev),
        .sw2_bit8_en(sw2), .mic_reset(m_rst), .stat_clear(s_clr),
        .unit_mm(mm), .stat_en(s_en), .memsw(msw), .segment_select(sg),
        .interval_sel(iv), .limit_en(le), .lower_limit_value(lo),
        .upper_limit_value(up), .ref_en(re), .ref_value(rf), .scale_sel(sc),
        .ocond_en(oe), .output_condition(oc), .output_timer_value(tm),
        .latch_timer_seconds(lt));
    mccu_sva u_mccu_sva (.ref_clk(ref_clk), .arst_n(arst_n), .op(lnk.op),
        .vld(lnk.vld), .data(lnk.data), .last(lnk.last), .rdy(lnk.rdy),
        .done(lnk.done), .err(lnk.err));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    function automatic logic [15:0] bcd(input int n, input int l, input int h);
        bcd = 16'h0000;
        for (int i = 0; i < n; i++)
            bcd[4*i +: 4] = 4'(l + $unsigned($random(seed)) % (h - l + 1));
    endfunction
    function automatic logic [28:0] lim(input int k);
        return {f[k+2][15:8] == mccu_pkg::SIGN_NEG, f[k+1][11:0], f[k]};
    endfunction
    // Words the unit must ignore get noise, so a leak shows in the settings.
    task automatic mk();
        for (int k = 0; k < 25; k++)
            f[k] = 16'($random(seed));
        f[0] = mccu_pkg::SET_COUNT;
        f[1] = bcd(1, 1, 5);
        f[2] = bcd(1, 1, 7);
        for (int k = 3; k < 12; k += 3) begin
            f[k] = bcd(4, 0, 9);
            f[k+1] = bcd(3, 0, 9);
            f[k+2] = {f[k+2][0] ? mccu_pkg::SIGN_NEG : mccu_pkg::SIGN_POS, 8'h00};
        end
        f[12] = bcd(1, 0, 3);
        f[16] = bcd(1, 0, 6);
        f[17] = bcd(3, 0, 9);
        f[18] = bcd(2, 0, 9);
        for (int k = 19; k < 25; k++)
            f[k] = bcd(1, 0, 1);
    endtask
    task automatic run(input mccu_pkg::mccu_op_t o, input logic bad);
        int pulses = 0;
        @(posedge ref_clk);
        #1 op = o;
        start = 1;
        @(posedge ref_clk);
        #1 start = 0;
        repeat (60) begin
            @(posedge ref_clk);
            #1 pulses += m_rst + s_clr;
            if (h_done || h_err)
                break;
        end
        `CHK("answer", {bad, !bad, 1'b0}, {h_err, h_done, h_busy})
        `CHK("pulse", 2 * (!bad && o == mccu_pkg::OP_INIT), pulses)
        if (!bad && o == mccu_pkg::OP_INIT)
            `CHK("init", {mm, s_en, msw}, {2'b10, f[4], f[3], f[2], f[1]})
        if (!bad && o == mccu_pkg::OP_SET) begin
            if (f[19][0]) e_sg = f[1][3:0];
            if (f[20][0]) e_iv = f[2][3:0];
            if (f[21][0]) {e_le, e_lo, e_up} = {1'b1, lim(3), lim(6)};
            if (f[22][0]) {e_re, e_rf, e_sc} = {1'b1, lim(9), f[12][3:0]};
            if (f[23][0]) {e_oe, e_oc, e_tm} = {1'b1, f[16][3:0], f[17][11:0]};
            if (f[24][0]) e_lt = f[18][7:0];
        end
        if (!bad && o == mccu_pkg::OP_RELEASE) begin
            {e_sg, e_iv} = 8'h11;
            if (f[21][0]) {e_le, e_lo, e_up} = '0;
            if (f[22][0]) {e_re, e_rf} = '0;
            if (f[23][0]) {e_oe, e_oc} = '0;
            if (f[24][0]) e_lt = 8'h00;
        end
        `CHK("cfg", {sg, iv, le, lo, up, re, rf, sc, oe, oc, tm, lt},
            {e_sg, e_iv, e_le, e_lo, e_up, e_re, e_rf, e_sc, e_oe, e_oc,
            e_tm, e_lt})
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 arst_n = 1;
        mk();
        run(mccu_pkg::OP_INIT, 0);
        flen = 5'h04;
        run(mccu_pkg::OP_INIT, 1);
        flen = 5'h05;
        for (int k = 0; k < 14; k++) begin
            mk();
            if (k > 7)
                f[bi[k-8]] = bv[k-8];
            run(mccu_pkg::OP_SET, k > 7);
        end
        mk();
        run(mccu_pkg::OP_RELEASE, 1);
        sw2 = 1;
        repeat (6) begin
            mk();
            run(mccu_pkg::OP_SET, 0);
            mk();
            run(mccu_pkg::OP_RELEASE, 0);
        end
        wrap_up();
    end
endmodule
